// ===== pal_array.v
`timescale 1ns/1ps
`default_nettype none
`include "pal_defs.vh"

module pal_array #(
  parameter N_IN  = `PAL_N_IN,
  parameter N_MC  = `PAL_N_MC,
  parameter ROW_W = `PAL_ROW_W,
  parameter ROWS  = `PAL_ROWS,
  parameter AW    = `PAL_ADDR_W
) (
  input  wire              ref_clk,
  input  wire              arst_n,
  input  wire [N_IN-1:0]   ded_in,
  input  wire [N_MC-1:0]   io_in,
  output wire [N_MC-1:0]   io_out,
  output wire [N_MC-1:0]   io_oe,
  input  wire [AW-1:0]     reg_addr,
  input  wire [ROW_W-1:0]  reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [ROW_W-1:0]  reg_rdata
);

  // Product terms of macrocell i: fewest at both ends of the array, most in the middle.
  function integer pal_nt;
    input integer i;
    begin
      if (i < N_MC / 2) begin
        pal_nt = `PAL_NT_MIN + `PAL_NT_STEP * i;
      end else begin
        pal_nt = `PAL_NT_MIN + `PAL_NT_STEP * (N_MC - 1 - i);
      end
    end
  endfunction

  // First fuse row of macrocell i: its enable row, then its sum rows.
  function integer pal_base;
    input integer i;
    integer j;
    begin
      pal_base = `PAL_ROW_RST + 1;
      for (j = 0; j < i; j = j + 1) begin
        pal_base = pal_base + 1 + pal_nt(j);
      end
    end
  endfunction

  reg  [ROW_W-1:0]       fuse_q [0:ROWS-1];
  reg  [N_MC-1:0]        fb_sel_q;
  reg  [N_MC-1:0]        pol_sel_q;
  reg                    preload_q;
  reg                    secure_q;
  reg  [N_IN-1:0]        in_meta_q;
  reg  [N_IN-1:0]        in_sync_q;
  reg  [N_MC-1:0]        io_meta_q;
  reg  [N_MC-1:0]        io_sync_q;
  reg                    clk_pin_prev_q;
  wire                   pin_clk_en;
  wire [ROWS*ROW_W-1:0]  fuse_flat;
  wire [N_MC-1:0]        mc_q;
  wire [N_MC-1:0]        feedback;
  wire [N_IN+N_MC-1:0]   sig;
  wire [ROW_W-1:0]       arr;
  wire                   rst_term;
  wire                   set_term;
  integer                r;

  // Pins arrive from outside the clock domain, so each passes two flops before the array sees it.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_meta_q <= {N_IN{1'b0}};
      in_sync_q <= {N_IN{1'b0}};
      io_meta_q <= {N_MC{1'b0}};
      io_sync_q <= {N_MC{1'b0}};
    end else begin
      in_meta_q <= ded_in;
      in_sync_q <= in_meta_q;
      io_meta_q <= io_in;
      io_sync_q <= io_meta_q;
    end
  end

  // Input 0 doubles as the register clock; its rising edge becomes a one-cycle enable.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_pin_prev_q <= 1'b0;
    end else begin
      clk_pin_prev_q <= in_sync_q[0];
    end
  end

  assign pin_clk_en = in_sync_q[0] & ~clk_pin_prev_q;

  // Feedback comes from the register or from the pin, which lets a disabled output act as an input.
  assign feedback = (fb_sel_q & io_sync_q) | (~fb_sel_q & mc_q);
  assign sig      = {feedback, in_sync_q};

  // Each signal reaches the array in true and complemented form.
  genvar k;
  generate
    for (k = 0; k < N_IN + N_MC; k = k + 1) begin : g_lit
      assign arr[2*k]   = sig[k];
      assign arr[2*k+1] = ~sig[k];
    end
  endgenerate

  generate
    for (k = 0; k < ROWS; k = k + 1) begin : g_flat
      assign fuse_flat[k*ROW_W +: ROW_W] = fuse_q[k];
    end
  endgenerate

  // One set and one reset term serve every register.
  assign rst_term = &(fuse_q[`PAL_ROW_RST] | arr);
  assign set_term = &(fuse_q[`PAL_ROW_SET] | arr);

  // Macrocells, each with its own term count and enable row.
  generate
    for (k = 0; k < N_MC; k = k + 1) begin : g_mc
      pal_mcell #(
        .NT    (pal_nt(k)),
        .ROW_W (ROW_W)
      ) u_mcell (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .arr_in     (arr),
        .sum_rows   (fuse_flat[(pal_base(k)+1)*ROW_W +: pal_nt(k)*ROW_W]),
        .oe_row     (fuse_flat[pal_base(k)*ROW_W +: ROW_W]),
        .rst_term   (rst_term),
        .set_term   (set_term),
        .pin_clk_en (pin_clk_en),
        .preload    (preload_q),
        .pin_level  (io_sync_q[k]),
        .fb_sel     (fb_sel_q[k]),
        .pol_sel    (pol_sel_q[k]),
        .q_q        (mc_q[k]),
        .pin_out_q  (io_out[k]),
        .pin_oe_q   (io_oe[k])
      );
    end
  endgenerate

  // Fuse rows and selects are written whole; the security bit only ever sets until reset.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (r = 0; r < ROWS; r = r + 1) begin
        fuse_q[r] <= `PAL_ROW_RESET;
      end
      fb_sel_q  <= `PAL_CFG_RESET;
      pol_sel_q <= `PAL_CFG_RESET;
      preload_q <= 1'b0;
      secure_q  <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr < ROWS) begin
        fuse_q[reg_addr] <= reg_wdata;
      end else if (reg_addr == `PAL_ADDR_CFG) begin
        fb_sel_q  <= reg_wdata[`PAL_CFG_FB_LSB +: N_MC];
        pol_sel_q <= reg_wdata[`PAL_CFG_POL_LSB +: N_MC];
      end else if (reg_addr == `PAL_ADDR_CTL) begin
        preload_q <= reg_wdata[`PAL_CTL_PRELOAD];
        secure_q  <= secure_q | reg_wdata[`PAL_CTL_SECURE];
      end
    end
  end

  // Readback answers one cycle after the strobe; a secured part shows every fuse as blown.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `PAL_ROW_RESET;
    end else if (reg_rd) begin
      reg_rdata <= `PAL_ROW_RESET;
      if (reg_addr < ROWS) begin
        reg_rdata <= secure_q ? `PAL_ROW_ONES : fuse_q[reg_addr];
      end else if (reg_addr == `PAL_ADDR_CFG) begin
        if (secure_q) begin
          reg_rdata <= `PAL_ROW_ONES;
        end else begin
          reg_rdata[`PAL_CFG_FB_LSB +: N_MC]  <= fb_sel_q;
          reg_rdata[`PAL_CFG_POL_LSB +: N_MC] <= pol_sel_q;
        end
      end else if (reg_addr == `PAL_ADDR_CTL) begin
        reg_rdata[`PAL_CTL_PRELOAD] <= preload_q;
        reg_rdata[`PAL_CTL_SECURE]  <= secure_q;
      end else if (reg_addr == `PAL_ADDR_STAT) begin
        reg_rdata[`PAL_STAT_Q_LSB +: N_MC]   <= mc_q;
        reg_rdata[`PAL_STAT_OE_LSB +: N_MC]  <= io_oe;
        reg_rdata[`PAL_STAT_PIN_LSB +: N_MC] <= io_out;
      end
    end else begin
      reg_rdata <= `PAL_ROW_RESET;
    end
  end

endmodule
`default_nettype wire

// ===== pal_array_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pal_array_chk (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [9:0]  io_out,
  input wire logic [9:0]  io_oe,
  input wire logic [7:0]  reg_addr,
  input wire logic [43:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [43:0] reg_rdata
);
  logic pl_q;
  logic sec_q;
  // Shadow of the control bits, so no check needs to look inside the array.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pl_q <= 1'b0;
      sec_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h85) begin
      pl_q <= reg_wdata[0];
      sec_q <= sec_q | reg_wdata[1];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_pins_reset: assert property ($rose(arst_n) |-> io_oe == 10'h000 && io_out == 10'h3FF)
    else $error("pins wrong after reset");
  a_rdata_idle: assert property (reg_rdata != 44'h0 |-> $past(reg_rd))
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h86 |=> reg_rdata == 44'h0)
    else $error("unmapped read not zero");
  a_secure_ones: assert property (sec_q && reg_rd && reg_addr < 8'h85 |=> reg_rdata == '1)
    else $error("secured read not all ones");
  a_ctl_readback: assert property (reg_rd && reg_addr == 8'h85 |=> reg_rdata[1:0] == $past({sec_q, pl_q}))
    else $error("control readback wrong");
  a_preload_off: assert property (pl_q [*6] |-> io_oe == 10'h000)
    else $error("pin driven in preload");
  a_stat_mirror: assert property (reg_rd && reg_addr == 8'h86 |=> reg_rdata[29:10] == $past({io_out, io_oe}))
    else $error("status does not mirror pins");
  a_cfg_readback: assert property (reg_wr && reg_addr == 8'h84 && !sec_q ##1 reg_rd && reg_addr == 8'h84
    |=> reg_rdata[19:0] == $past(reg_wdata[19:0], 2))
    else $error("config readback wrong");
endmodule
bind pal_array pal_array_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .io_out(io_out), .io_oe(io_oe),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// ===== pal_board.sv
`timescale 1ns/1ps
`default_nettype none
module pal_board (
  input  wire logic [9:0] io_out,
  input  wire logic [9:0] io_oe,
  input  wire logic [9:0] drv_en,
  input  wire logic [9:0] drv_val,
  output logic      [9:0] io_in
);
  // A released pin is pulled high, so no stale level survives the release.
  assign io_in = (io_oe & io_out) | (~io_oe & ((drv_en & drv_val) | ~drv_en));
endmodule
`default_nettype wire

// ===== pal_defs.vh
`ifndef PAL_DEFS_VH
`define PAL_DEFS_VH

// Array geometry: dedicated inputs, macrocells, fuse row width (true and complement of 22 signals).
`define PAL_N_IN        12
`define PAL_N_MC        10
`define PAL_ROW_W       44
`define PAL_ROWS        132
`define PAL_ADDR_W      8

// Product term allocation: 8 terms at the ends of the array, rising by 2 toward the middle.
`define PAL_NT_MIN      8
`define PAL_NT_STEP     2

// Fuse rows holding the shared terms.
`define PAL_ROW_RST     0
`define PAL_ROW_SET     131

// Register addresses beyond the fuse rows.
`define PAL_ADDR_CFG    8'h84
`define PAL_ADDR_CTL    8'h85
`define PAL_ADDR_STAT   8'h86

// Field positions.
`define PAL_CFG_FB_LSB  0
`define PAL_CFG_POL_LSB 10
`define PAL_CTL_PRELOAD 0
`define PAL_CTL_SECURE  1
`define PAL_STAT_Q_LSB  0
`define PAL_STAT_OE_LSB 10
`define PAL_STAT_PIN_LSB 20

// Reset values.
`define PAL_ROW_RESET   44'h000_0000_0000
`define PAL_ROW_ONES    44'hFFF_FFFF_FFFF
`define PAL_CFG_RESET   10'h000

`endif

// ===== pal_mcell.v
`timescale 1ns/1ps
`default_nettype none
`include "pal_defs.vh"

module pal_mcell #(
  parameter NT    = 8,
  parameter ROW_W = 44
) (
  input  wire                 ref_clk,
  input  wire                 arst_n,
  input  wire [ROW_W-1:0]     arr_in,
  input  wire [NT*ROW_W-1:0]  sum_rows,
  input  wire [ROW_W-1:0]     oe_row,
  input  wire                 rst_term,
  input  wire                 set_term,
  input  wire                 pin_clk_en,
  input  wire                 preload,
  input  wire                 pin_level,
  input  wire                 fb_sel,
  input  wire                 pol_sel,
  output reg                  q_q,
  output reg                  pin_out_q,
  output reg                  pin_oe_q
);

  wire [NT-1:0] pt;
  wire          sum;
  wire          oe_term;
  reg           q_d;
  reg           pin_out_d;

  // An intact fuse (0) keeps its literal in the AND; a blown fuse (1) drops it.
  genvar t;
  generate
    for (t = 0; t < NT; t = t + 1) begin : g_pt
      assign pt[t] = &(sum_rows[t*ROW_W +: ROW_W] | arr_in);
    end
  endgenerate

  assign sum     = |pt;
  assign oe_term = &(oe_row | arr_in);

  // Register next state: reset term first, then preload, set, and the sum on a pin clock edge.
  always @* begin
    q_d = q_q;
    if (rst_term) begin
      q_d = 1'b0;
    end else if (pin_clk_en) begin
      if (preload) begin
        q_d = pol_sel ? pin_level : ~pin_level;
      end else if (set_term) begin
        q_d = 1'b1;
      end else begin
        q_d = sum;
      end
    end
  end

  // The pin follows the register or bypasses it, always through the polarity select.
  always @* begin
    if (fb_sel) begin
      pin_out_d = pol_sel ? sum : ~sum;
    end else begin
      pin_out_d = pol_sel ? q_d : ~q_d;
    end
  end

  // Reset value of the pin is high, matching a cleared register in the default active-low setup.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_q       <= 1'b0;
      pin_out_q <= 1'b1;
      pin_oe_q  <= 1'b0;
    end else begin
      q_q       <= q_d;
      pin_out_q <= pin_out_d;
      pin_oe_q  <= oe_term & ~preload;
    end
  end

endmodule
`default_nettype wire

// ===== pal_output_macrocell_array_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pal_output_macrocell_array_tb;
  localparam logic [43:0] all1 = 44'hFFF_FFFF_FFFF;
  logic            ref_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [11:0]     ded_in = 12'h000;
  logic [7:0]      reg_addr = 8'h00;
  logic [43:0]     reg_wdata = 44'h0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [9:0]      drv_en = 10'h000;
  logic [9:0]      drv_val = 10'h000;
  wire logic [9:0] io_in;
  wire logic [9:0] io_out;
  wire logic [9:0] io_oe;
  wire logic [43:0] reg_rdata;
  int              miscompares = 0;
  int              check_count = 0;
  int              base [10] = '{1, 10, 21, 34, 49, 66, 83, 98, 111, 122};
  int              nt [10] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
  always #2.5 ref_clk = ~ref_clk;
  pal_array dut (.ref_clk(ref_clk), .arst_n(arst_n), .ded_in(ded_in), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  pal_board board (.io_out(io_out), .io_oe(io_oe), .drv_en(drv_en), .drv_val(drv_val), .io_in(io_in));
  task automatic chk(input string n, input logic [43:0] e, input logic [43:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobes drop at the edge that takes them; the 1 ns step keeps drivers off that edge.
  task automatic nap(input int n);
    repeat (n) @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [43:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    nap(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [43:0] e, input string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    nap(1);
    chk(n, e, reg_rdata);
  endtask
  // The pin clock is slow against ref_clk, so the synchroniser always sees it.
  task automatic pclk();
    ded_in[0] <= 1'b1;
    nap(4);
    ded_in[0] <= 1'b0;
    nap(4);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Power-up, bus, shared terms, combinational feedback, preload and security in turn.
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    nap(1);
    chk("oe", 10'h000, io_oe);
    chk("out", 10'h3FF, io_out);
    rc(8'h86, 44'h3FF00000, "stat");
    rc(8'h84, 44'h0, "cfg");
    $display("reset test done");
    wr(8'h07, 44'hA5A_5A5A_5A5A);
    rc(8'h07, 44'hA5A_5A5A_5A5A, "row");
    wr(8'h86, all1);
    rc(8'h90, 44'h0, "unmapped");
    wr(8'h07, 44'h0);
    $display("bus test done");
    for (int i = 0; i < 10; i++) wr(8'(base[i]), all1);
    wr(8'h84, 44'hFFC00);
    rc(8'h84, 44'hFFC00, "cfg");
    wr(8'h83, all1);
    pclk();
    chk("set", 10'h3FF, io_out);
    chk("oe", 10'h3FF, io_oe);
    wr(8'h83, 44'h0);
    wr(8'h84, 44'h3C000);
    nap(4);
    chk("pol", 10'h0F0, io_out);
    wr(8'h00, all1);
    nap(3);
    chk("clr", 10'h30F, io_out);
    rc(8'h86, 44'h30FFFC00, "stat");
    wr(8'h00, 44'h0);
    wr(8'h84, 44'hFFC00);
    for (int i = 0; i < 10; i++) wr(8'(base[i] + nt[i]), all1);
    pclk();
    chk("sum", 10'h3FF, io_out);
    $display("shared term test done");
    wr(8'h09, 44'hBFF_FFFF_FFFF);
    wr(8'h7A, 44'h0);
    wr(8'h84, 44'hFFFFF);
    for (int v = 0; v < 2; v++) begin
      drv_en <= 10'h200;
      drv_val <= {v[0], 9'h000};
      nap(5);
      chk("fb", v, io_out[0]);
    end
    chk("oe9", 1'b0, io_oe[9]);
    $display("feedback test done");
    wr(8'h84, 44'hFDC00);
    wr(8'h85, 44'h1);
    drv_en <= 10'h008;
    drv_val <= 10'h008;
    nap(6);
    chk("pre oe", 10'h000, io_oe);
    pclk();
    drv_en <= 10'h000;
    wr(8'h85, 44'h0);
    nap(4);
    rc(8'h86, 44'h3FF7FFF7, "stat");
    $display("preload test done");
    wr(8'h85, 44'h2);
    rc(8'h05, all1, "row sec");
    rc(8'h84, all1, "cfg sec");
    rc(8'h85, 44'h2, "ctl");
    $display("secure test done");
    // A second reset in mid-run must release the pins at once (enables low, outputs high) and drop the sticky security bit.
    arst_n <= 1'b0;
    #1;
    chk("rst out", 10'h3FF, io_out);
    chk("rst oe", 10'h000, io_oe);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    nap(1);
    rc(8'h86, 44'h3FF00000, "stat rst");
    rc(8'h85, 44'h0, "ctl rst");
    $display("second reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
